// >>> pcrb_bank.sv
// Purpose: I2C slave holding PLL configuration registers 0 to 3
// Assumes: scl and sda inputs are synchronous to ref_clk_in and much slower
// Notes:   Registers 4 to 20 answer but read zero and ignore writes
// Operation
// (R1) Answer only address 10101 followed by the two address pins.
// (R2) Direction bit one reads from device, zero writes to it.
// (R3) Acknowledge is data low, not-acknowledge is data released high.
// (R4) Twenty-one registers addressable; 0-3 PLL, 4 inputs, 5-20 outputs.
// (R5) Host writes zeros into reserved top bits of registers 0 and 3.
// (R6) Register 0 bit 0 always reads zero whatever is written.
// (R7) Register 0 bits 9:7 choose loop filter capacitor.
// (R8) Register 0 bits 6:4 choose loop filter resistor.
// (R9) Register 0 bits 3:1 choose charge pump current.
// (R10) Register 1 bits 15:2 reference divider, ratio is value plus one.
// (R11) First feedback divider is reg1[1:0] over reg2[15:8], ratio plus one.
// (R12) Register 2 bits 7:0 second feedback divider, ratio plus one.
// (R13) Register 3 bits 12:10 enable refclk, loss, lock on status pin B.
// (R14) Register 3 bits 9:7 enable refclk, loss, lock on status pin A.
// (R15) Register 3 bit 6 low holds device in reset, registers kept.
// (R16) Register 3 bit 5 low forces output divider synchronization.
// (R17) Register 3 bit 4 high enables PLL and VCO calibration.
// (R18) Register 3 bits 3:2 second prescaler 4, 5, 6; code 11 reserved.
// (R19) Register 3 bits 1:0 first prescaler, same coding, feeds feedback.
// (R20) Registers are sixteen bits sent as two bytes, high byte first.
// (R21) Host avoids reserved prescaler code and unlisted select codes.
`include "pcrb_map.svh"
`timescale 1ns/100ps
module pcrb_bank (
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        nrst_in,
   // Serial pins and address straps
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_out,
   input  wire logic        addr_pin_high_in,
   input  wire logic        addr_pin_low_in,
   // Indications from the PLL
   input  wire logic        refclk_sel_in,
   input  wire logic        ref_loss_in,
   input  wire logic        pll_lock_in,
   // Status pins
   output logic             status_a_out,
   output logic             status_b_out,
   // Analog settings
   output logic [2:0]       filter_cap_select_out,
   output logic [2:0]       filter_res_select_out,
   output logic [2:0]       pump_current_select_out,
   output logic [14:0]      reference_divider_ratio_out,
   output logic [10:0]      feedback_first_ratio_out,
   output logic [8:0]       feedback_second_ratio_out,
   output logic [2:0]       prescaler_first_ratio_out,
   output logic [2:0]       prescaler_second_ratio_out,
   // Device controls
   output logic             soft_reset_active_out,
   output logic             divider_sync_force_out,
   output logic             vco_calibration_enable_out
);

   pcrb_pkg::pcrb_state_type state;
   logic        scl_q;
   logic        sda_q;
   logic [3:0]  cnt;
   logic [7:0]  shift;
   logic [7:0]  tx;
   logic [7:0]  ptr;
   logic [7:0]  wr_hi;
   logic [1:0]  wbyte;
   logic        rd_lo;
   logic        ack_pend;
   logic        strap_done;
   logic [1:0]  strap;
   logic [15:0] regs [0:3];
   logic        scl_rise;
   logic        scl_fall;
   logic        start_cond;
   logic        stop_cond;
   logic        byte_done;
   logic        slot_done;
   logic        commit;
   logic [7:0]  in_byte;
   logic [7:0]  next_ptr;
   logic [2:0]  ind;
   logic [15:0] rd_cur;
   logic [15:0] rd_next;

   // Register contents by number, unimplemented ones read zero
   function automatic logic [15:0] pcrb_read(input logic [7:0] p);
      logic [15:0] v;
      v = 16'h0000;
      if (p <= `PCRB_STATUS_RESET_PRESCALERS) begin
         v = regs[p[1:0]];
      end
      return v;
   endfunction : pcrb_read

   // Prescaler code to divide ratio, reserved code gives zero
   function automatic logic [2:0] pcrb_ps_ratio(input logic [1:0] c);
      logic [2:0] r;
      r = 3'h0;
      if (c != 2'h3) begin
         r = 3'h4 + {1'b0, c};
      end
      return r;
   endfunction : pcrb_ps_ratio

   // Bus event decoding
   assign scl_rise   = scl_in & ~scl_q;
   assign scl_fall   = ~scl_in & scl_q;
   assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
   assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;
   assign in_byte    = {shift[6:0], sda_in};
   assign byte_done  = scl_rise && (cnt == 4'h7);
   assign slot_done  = scl_rise && (cnt == 4'h8);
   assign commit     = byte_done && (state == pcrb_pkg::PCRB_WRITE) && (wbyte == 2'h2);
   assign next_ptr   = ptr + 8'h01;

   // Words at the pointer and the one after it, re-read whenever a register changes
   always_comb begin
      rd_cur  = pcrb_read(ptr);
      rd_next = pcrb_read(next_ptr);
   end

   // Previous pin levels
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   // Address straps caught once after reset release
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         strap      <= 2'h0;
         strap_done <= 1'b0;
      end else if (!strap_done) begin
         strap      <= {addr_pin_high_in, addr_pin_low_in};
         strap_done <= 1'b1;
      end
   end

   // Serial protocol engine
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state    <= pcrb_pkg::PCRB_IDLE;
         cnt      <= 4'h0;
         shift    <= 8'h00;
         tx       <= 8'h00;
         ptr      <= 8'h00;
         wr_hi    <= 8'h00;
         wbyte    <= 2'h0;
         rd_lo    <= 1'b0;
         ack_pend <= 1'b0;
      end else if (start_cond) begin
         state    <= pcrb_pkg::PCRB_ADDR;
         cnt      <= 4'h0;
         ack_pend <= 1'b0;
      end else if (stop_cond) begin
         state    <= pcrb_pkg::PCRB_IDLE;
         ack_pend <= 1'b0;
      end else if (scl_rise && state != pcrb_pkg::PCRB_IDLE) begin
         if (cnt == 4'h8) begin
            cnt      <= 4'h0;
            ack_pend <= 1'b0;
         end else begin
            cnt   <= cnt + 4'h1;
            shift <= in_byte;
         end
         unique case (state)
            pcrb_pkg::PCRB_ADDR: begin
               if (byte_done) begin
                  if (in_byte[7:1] == {`PCRB_SLAVE_FIXED, strap}) begin // R1
                     ack_pend <= 1'b1;                                   // R3
                     wbyte    <= 2'h0;
                     rd_lo    <= 1'b0;
                     tx       <= rd_cur[15:8];
                     state    <= in_byte[0] ? pcrb_pkg::PCRB_READ : pcrb_pkg::PCRB_WRITE; // R2
                  end else begin
                     state <= pcrb_pkg::PCRB_IDLE;
                  end
               end
            end
            pcrb_pkg::PCRB_WRITE: begin
               if (byte_done) begin
                  ack_pend <= 1'b1; // R3
                  unique case (wbyte)
                     2'h0: begin
                        ptr   <= in_byte;
                        wbyte <= 2'h1;
                     end
                     2'h1: begin
                        wr_hi <= in_byte; // R20
                        wbyte <= 2'h2;
                     end
                     default: begin
                        ptr   <= next_ptr;
                        wbyte <= 2'h1;
                     end
                  endcase
               end
            end
            pcrb_pkg::PCRB_READ: begin
               if (slot_done) begin
                  if (ack_pend) begin
                     tx    <= rd_cur[15:8];        // Address slot keeps high byte first
                  end else if (sda_in) begin
                     state <= pcrb_pkg::PCRB_IDLE; // R3
                  end else if (!rd_lo) begin
                     tx    <= rd_cur[7:0];         // R20
                     rd_lo <= 1'b1;
                  end else begin
                     tx    <= rd_next[15:8];       // R4
                     ptr   <= next_ptr;
                     rd_lo <= 1'b0;
                  end
               end
            end
            default: begin
               state <= pcrb_pkg::PCRB_IDLE;
            end
         endcase
      end
   end

   // Register file, reserved bits held at zero
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         regs[0] <= `PCRB_REG0_RST;
         regs[1] <= `PCRB_REG1_RST;
         regs[2] <= `PCRB_REG2_RST;
         regs[3] <= `PCRB_REG3_RST;
      end else if (commit && ptr <= `PCRB_STATUS_RESET_PRESCALERS) begin // R4
         unique case (ptr[1:0])
            2'h0: regs[0] <= {wr_hi, in_byte} & `PCRB_REG0_KEEP; // R6
            2'h1: regs[1] <= {wr_hi, in_byte};                    // R20
            2'h2: regs[2] <= {wr_hi, in_byte};
            2'h3: regs[3] <= {wr_hi, in_byte} & `PCRB_REG3_KEEP;
         endcase
      end
   end

   // Open-drain data drive, set while clock is low, released at start or stop
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sda_oe_out <= 1'b0;
      end else if (start_cond || stop_cond) begin
         sda_oe_out <= 1'b0;
      end else if (scl_fall) begin
         if (cnt == 4'h8) begin
            sda_oe_out <= ack_pend; // R3
         end else if (state == pcrb_pkg::PCRB_READ) begin
            sda_oe_out <= ~tx[3'h7 - cnt[2:0]];
         end else begin
            sda_oe_out <= 1'b0;
         end
      end
   end

   assign sda_out = 1'b0;

   // Status pin routing
   assign ind          = {refclk_sel_in, ref_loss_in, pll_lock_in};
   assign status_b_out = |(ind & regs[3][`PCRB_B_REFCLK:`PCRB_B_LOCK]); // R13
   assign status_a_out = |(ind & regs[3][`PCRB_A_REFCLK:`PCRB_A_LOCK]); // R14

   // Analog setting fields
   assign filter_cap_select_out   = regs[0][`PCRB_CAP_MSB:`PCRB_CAP_LSB];   // R7
   assign filter_res_select_out   = regs[0][`PCRB_RES_MSB:`PCRB_RES_LSB];   // R8
   assign pump_current_select_out = regs[0][`PCRB_PUMP_MSB:`PCRB_PUMP_LSB]; // R9
   assign reference_divider_ratio_out =
      {1'b0, regs[1][`PCRB_REFDIV_MSB:`PCRB_REFDIV_LSB]} + 15'h0001;         // R10
   assign feedback_first_ratio_out =
      {1'b0, regs[1][`PCRB_FBHI_MSB:0], regs[2][`PCRB_FBLO_MSB:`PCRB_FBLO_LSB]} + 11'h001; // R11
   assign feedback_second_ratio_out = {1'b0, regs[2][`PCRB_FB2_MSB:0]} + 9'h001; // R12
   assign prescaler_second_ratio_out = pcrb_ps_ratio(regs[3][`PCRB_PS2_MSB:`PCRB_PS2_LSB]); // R18
   assign prescaler_first_ratio_out  = pcrb_ps_ratio(regs[3][`PCRB_PS1_MSB:0]);             // R19

   // Device controls
   assign soft_reset_active_out      = ~regs[3][`PCRB_SOFT_RST]; // R15
   assign divider_sync_force_out     = ~regs[3][`PCRB_SYNC_REL]; // R16
   assign vco_calibration_enable_out = regs[3][`PCRB_VCO_CAL];   // R17

   // Checks
   a_addr_match: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R1
      (state == pcrb_pkg::PCRB_ADDR && byte_done && !start_cond && !stop_cond
       && in_byte[7:1] == {`PCRB_SLAVE_FIXED, strap}) |=> ack_pend)
      else $error("matching address not acknowledged");
   a_addr_miss: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R1
      (state == pcrb_pkg::PCRB_ADDR && byte_done && !start_cond && !stop_cond
       && in_byte[7:1] != {`PCRB_SLAVE_FIXED, strap}) |=> state == pcrb_pkg::PCRB_IDLE && !ack_pend)
      else $error("foreign address answered");
   a_dir_read: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R2
      (state == pcrb_pkg::PCRB_ADDR && byte_done && !start_cond && !stop_cond
       && in_byte == {`PCRB_SLAVE_FIXED, strap, 1'b1}) |=> state == pcrb_pkg::PCRB_READ)
      else $error("read direction not taken");
   a_ack_drive: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R3
      (scl_fall && cnt == 4'h8 && ack_pend && !start_cond && !stop_cond) |=> sda_oe_out && !sda_out)
      else $error("acknowledge not driven low");
   a_reg0_bit0: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R6
      regs[0][0] == 1'b0 && regs[0][15:10] == 6'h00)
      else $error("register 0 fixed bits not zero");
   a_high_ignored: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R4
      (commit && ptr > `PCRB_STATUS_RESET_PRESCALERS) |=> $stable(regs[3]) && $stable(regs[0]))
      else $error("write beyond bank changed registers");
   a_word_pair: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R20
      (commit && ptr == `PCRB_REFERENCE_DIVIDER_AND_FB_HI && !start_cond && !stop_cond)
      |=> regs[1] == {$past(wr_hi), $past(in_byte)})
      else $error("word not assembled high byte first");
   a_soft_reset: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R15
      (commit && ptr == `PCRB_STATUS_RESET_PRESCALERS && !in_byte[`PCRB_SOFT_RST] && !start_cond && !stop_cond)
      |=> soft_reset_active_out ##1 soft_reset_active_out || commit)
      else $error("soft reset not held");
   a_sync_force: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R16
      (commit && ptr == `PCRB_STATUS_RESET_PRESCALERS && !in_byte[`PCRB_SYNC_REL] && !start_cond && !stop_cond)
      |=> divider_sync_force_out)
      else $error("divider sync not forced");
   a_status_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R14
      (pll_lock_in && regs[3][`PCRB_A_LOCK]) |-> status_a_out)
      else $error("lock not shown on pin A");
   a_ps_ratio: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R19
      (regs[3][`PCRB_PS1_MSB:0] == 2'h1) |-> prescaler_first_ratio_out == 3'h5)
      else $error("first prescaler ratio wrong");

endmodule : pcrb_bank

// >>> pcrb_bank_tb_top.sv
// Purpose: Self-checking bench for the PLL configuration bank
// Assumes: Host model drives the serial pins, data line pulled up
// Notes:   Fixed xorshift seed, corner values first
`timescale 1ns/100ps
`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin miscompares++; \
   $display("[FAIL] t=%0t got %0h exp %0h", $time, (act), (exp)); end end
module pcrb_bank_tb_top;
   logic        ref_clk_in, nrst_in, scl, host_oe, dut_oe, dut_sda, sda_wire;
   logic        addr_high, addr_low, refclk_sel, ref_loss, pll_lock;
   logic        status_a, status_b, soft_rst, sync_force, vco_cal;
   logic [2:0]  cap, res, pump, ps_first, ps_second;
   logic [14:0] ref_ratio;
   logic [10:0] fb_first;
   logic [8:0]  fb_second;
   logic [15:0] exp_reg [4];
   logic [15:0] wmask [4] = '{16'h03FF, 16'hFFFF, 16'hFFFF, 16'h1FFF};
   logic [15:0] v;
   logic [3:0]  acks;
   logic [6:0]  dev;
   logic [31:0] seed = 32'h215344B6;
   int          miscompares = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   // Open-drain data line with pull-up
   assign sda_wire = (dut_oe ? dut_sda : 1'b1) & ~host_oe;
   pcrb_host i_pcrb_host (.ref_clk_in(ref_clk_in), .sda_in(sda_wire), .scl_out(scl), .sda_oe_out(host_oe));
   pcrb_bank i_pcrb_bank (
      .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(dut_sda), .sda_oe_out(dut_oe), .addr_pin_high_in(addr_high), .addr_pin_low_in(addr_low),
      .refclk_sel_in(refclk_sel), .ref_loss_in(ref_loss), .pll_lock_in(pll_lock),
      .status_a_out(status_a), .status_b_out(status_b), .filter_cap_select_out(cap),
      .filter_res_select_out(res), .pump_current_select_out(pump), .reference_divider_ratio_out(ref_ratio),
      .feedback_first_ratio_out(fb_first), .feedback_second_ratio_out(fb_second),
      .prescaler_first_ratio_out(ps_first), .prescaler_second_ratio_out(ps_second),
      .soft_reset_active_out(soft_rst), .divider_sync_force_out(sync_force),
      .vco_calibration_enable_out(vco_cal));
   // Clock and hang guard
   initial ref_clk_in = 1'b0;
   always #12.5 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         miscompares++;
         final_report();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function automatic logic [2:0] presc(input logic [1:0] c);
      return (c == 2'b11) ? 3'h0 : 3'h4 + {1'b0, c};
   endfunction : presc
   task automatic wr(input logic [7:0] ptr, input logic [15:0] val);
      i_pcrb_host.write_reg(dev, ptr, val, acks);
      `CHK(acks, 4'h0)
   endtask : wr
   task automatic rd_chk(input logic [7:0] ptr, input logic [15:0] e);
      logic [15:0] got;
      i_pcrb_host.read_reg(dev, ptr, got, acks);
      `CHK(acks, 4'h0)
      `CHK(got, e)
   endtask : rd_chk
   task automatic check_settings;
      `CHK(cap, exp_reg[0][9:7])
      `CHK(res, exp_reg[0][6:4])
      `CHK(pump, exp_reg[0][3:1])
      `CHK(ref_ratio, {1'b0, exp_reg[1][15:2]} + 15'h1)
      `CHK(fb_first, {1'b0, exp_reg[1][1:0], exp_reg[2][15:8]} + 11'h1)
      `CHK(fb_second, {1'b0, exp_reg[2][7:0]} + 9'h1)
      `CHK(ps_first, presc(exp_reg[3][1:0]))
      `CHK(ps_second, presc(exp_reg[3][3:2]))
      `CHK(soft_rst, ~exp_reg[3][6])
      `CHK(sync_force, ~exp_reg[3][5])
      `CHK(vco_cal, exp_reg[3][4])
      for (int r = 0; r < 4; r++) rd_chk(r[7:0], exp_reg[r]);
   endtask : check_settings
   task automatic final_report;
      $display("counts: checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report
   // Main sequence
   initial begin
      nrst_in = 1'b0;
      addr_high = 1'b1;
      addr_low = 1'b0;
      {refclk_sel, ref_loss, pll_lock} = 3'b000;
      dev = 7'h56;
      repeat (10) @(posedge ref_clk_in);
      `CHK(dut_oe, 1'b0)
      nrst_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      exp_reg = '{16'h0000, 16'h0000, 16'h0000, 16'h0060};
      check_settings();
      $display("test reset values done");
      // Corners then random settings, bit 0 of register 0 may be written high
      for (int n = 0; n < 8; n++) begin
         for (int r = 0; r < 4; r++) begin
            seed = xs(seed);
            v = (n == 0) ? 16'h0000 : (n == 1) ? 16'hFFFF : seed[15:0];
            if (v[1:0] == 2'b11) v[1:0] = 2'b10;
            if (v[3:2] == 2'b11) v[3:2] = 2'b01;
            wr(r[7:0], v & wmask[r]);
            exp_reg[r] = v & wmask[r] & ((r == 0) ? 16'hFFFE : 16'hFFFF);
         end
         check_settings();
      end
      $display("test settings done");
      // Status pin enables against every indication pattern
      for (int k = 0; k < 8; k++) begin
         exp_reg[3] = {3'b000, ~k[2:0], k[2:0], 7'h70};
         wr(8'h03, exp_reg[3]);
         for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk_in);
            {refclk_sel, ref_loss, pll_lock} <= i[2:0];
            @(posedge ref_clk_in);
            `CHK(status_a, |(exp_reg[3][9:7] & {refclk_sel, ref_loss, pll_lock}))
            `CHK(status_b, |(exp_reg[3][12:10] & {refclk_sel, ref_loss, pll_lock}))
         end
      end
      $display("test status pins done");
      // Foreign addresses are not acknowledged and change nothing
      wr(8'h01, 16'h1234);
      foreach (wmask[j]) begin
         i_pcrb_host.write_reg((j == 0) ? 7'h57 : (j == 1) ? 7'h54 : 7'h16, 8'h01, 16'hBEEF, acks);
         `CHK(acks, 4'hF)
      end
      rd_chk(8'h01, 16'h1234);
      // Channel registers answer but hold nothing here
      wr(8'h04, seed[31:16]);
      wr(8'h14, 16'hFFFF);
      rd_chk(8'h04, 16'h0000);
      rd_chk(8'h14, 16'h0000);
      $display("test addressing done");
      final_report();
   end
endmodule : pcrb_bank_tb_top

// >>> pcrb_host.sv
// Purpose: Behavioural serial host that programs the PLL configuration bank
// Assumes: Data line has a pull-up; clock idles high between frames
// Notes:   Clock high lasts four reference cycles, clock low five
`timescale 1ns/100ps
module pcrb_host (
   // Reference clock and sensed data line
   input  wire logic ref_clk_in,
   input  wire logic sda_in,
   // Host drives
   output logic      scl_out,
   output logic      sda_oe_out
);
   // Idle bus at time zero
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   // One clock level
   task automatic half_bit;
      repeat (4) @(posedge ref_clk_in);
   endtask : half_bit
   // Bit slot: data set with clock low, sampled at end of high
   task automatic clk_bit(input logic pull, output logic seen);
      @(posedge ref_clk_in);
      sda_oe_out <= pull;
      half_bit();
      scl_out <= 1'b1;
      half_bit();
      seen = sda_in;
      scl_out <= 1'b0;
   endtask : clk_bit
   // Start or repeated start: data falls while clock high
   task automatic start_cond;
      @(posedge ref_clk_in);
      sda_oe_out <= 1'b0;
      half_bit();
      scl_out <= 1'b1;
      half_bit();
      sda_oe_out <= 1'b1;
      half_bit();
      scl_out <= 1'b0;
   endtask : start_cond
   // Stop: data rises while clock high
   task automatic stop_cond;
      @(posedge ref_clk_in);
      sda_oe_out <= 1'b1;
      half_bit();
      scl_out <= 1'b1;
      half_bit();
      sda_oe_out <= 1'b0;
      half_bit();
   endtask : stop_cond
   // Byte out, top bit first, then the acknowledge slot
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(~b[i], s);
      end
      clk_bit(1'b0, ack);
   endtask : send_byte
   // Byte in, then acknowledge low or leave high on the last
   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b0, b[i]);
      end
      clk_bit(~last, s);
   endtask : recv_byte
   // Single register write: address, pointer, high then low byte
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [15:0] val,
                            output logic [3:0] acks);
      start_cond();
      send_byte({dev, 1'b0}, acks[3]);
      send_byte(ptr, acks[2]);
      send_byte(val[15:8], acks[1]);
      send_byte(val[7:0], acks[0]);
      stop_cond();
   endtask : write_reg
   // Pointer write, repeated start, two-byte read ending on not-acknowledge
   task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [15:0] val,
                           output logic [3:0] acks);
      start_cond();
      send_byte({dev, 1'b0}, acks[3]);
      send_byte(ptr, acks[2]);
      start_cond();
      send_byte({dev, 1'b1}, acks[1]);
      recv_byte(1'b0, val[15:8]);
      recv_byte(1'b1, val[7:0]);
      acks[0] = 1'b0;
      stop_cond();
   endtask : read_reg
endmodule : pcrb_host

// >>> pcrb_map.svh
// Purpose: Offsets, field positions, reset values and fixed codes of the PLL configuration bank
// Assumes: Registers are sixteen bits, numbered by the pointer byte
// Notes:   Included by its bare name
`ifndef PCRB_MAP_SVH
`define PCRB_MAP_SVH

// Register numbers
`define PCRB_LOOP_FILTER_AND_PUMP        8'h00
`define PCRB_REFERENCE_DIVIDER_AND_FB_HI 8'h01
`define PCRB_FEEDBACK_DIVIDERS_LOW       8'h02
`define PCRB_STATUS_RESET_PRESCALERS     8'h03
`define PCRB_LAST_REG                    8'h14

// Register 0 fields
`define PCRB_CAP_MSB      9
`define PCRB_CAP_LSB      7
`define PCRB_RES_MSB      6
`define PCRB_RES_LSB      4
`define PCRB_PUMP_MSB     3
`define PCRB_PUMP_LSB     1
`define PCRB_REG0_KEEP    16'h03FE

// Register 1 and 2 fields
`define PCRB_REFDIV_MSB   15
`define PCRB_REFDIV_LSB   2
`define PCRB_FBHI_MSB     1
`define PCRB_FBLO_MSB     15
`define PCRB_FBLO_LSB     8
`define PCRB_FB2_MSB      7

// Register 3 fields
`define PCRB_B_REFCLK     12
`define PCRB_B_LOSS       11
`define PCRB_B_LOCK       10
`define PCRB_A_REFCLK     9
`define PCRB_A_LOSS       8
`define PCRB_A_LOCK       7
`define PCRB_SOFT_RST     6
`define PCRB_SYNC_REL     5
`define PCRB_VCO_CAL      4
`define PCRB_PS2_MSB      3
`define PCRB_PS2_LSB      2
`define PCRB_PS1_MSB      1
`define PCRB_REG3_KEEP    16'h1FFF

// Reset values
`define PCRB_REG0_RST     16'h0000
`define PCRB_REG1_RST     16'h0000
`define PCRB_REG2_RST     16'h0000
`define PCRB_REG3_RST     16'h0060

// Slave address upper five bits
`define PCRB_SLAVE_FIXED  5'h15

`endif

// >>> pcrb_pkg.sv
// Purpose: Types of the PLL configuration bank
// Assumes: Constants live in pcrb_map.svh
// Notes:   Serial engine states only
package pcrb_pkg;
   typedef enum logic [1:0] {PCRB_IDLE, PCRB_ADDR, PCRB_WRITE, PCRB_READ} pcrb_state_type;
endpackage : pcrb_pkg
